// ===== bench/cvt_horiz_source.sv
// Horizontal unit model giving character and line strobes
`timescale 1ns/1ps
module cvt_horiz_source #(
    parameter LINE = 8
) (
    // Clock and reset
    input  wire i_core_clk,
    input  wire i_reset,
    // Strobes
    output reg  o_char_en,
    output reg  o_hsync_start
);
    reg [7:0] pos;
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            pos           <= 8'h00;
            o_char_en     <= 1'b0;
            o_hsync_start <= 1'b0;
        end else begin
            pos           <= (pos == LINE - 1) ? 8'h00 : pos + 8'h01;
            o_char_en     <= ~o_char_en;
            o_hsync_start <= (pos == LINE - 1);
        end
    end
endmodule // cvt_horiz_source

// ===== bench/cvt_vertical_timing_bench.sv
// Self-checking bench for the vertical timing unit
`timescale 1ns/1ps
module cvt_vertical_timing_bench;
    reg         i_core_clk = 1'b0;
    reg         i_reset = 1'b1;
    reg  [7:0]  i_reg_index = 8'h00;
    reg         i_reg_wr = 1'b0;
    reg         i_reg_rd = 1'b0;
    reg  [7:0]  i_reg_wdata = 8'h00;
    reg         i_refresh_one = 1'b0;
    wire [7:0]  rdata;
    wire        char_en, hsync, vs, vb, vd, irq, pend, ul;
    wire [2:0]  refr;
    wire [2:0]  vt = {vd, vb, vs};
    integer     fails = 0, cmp_count = 0, hs_cnt = 0, base, i;
    reg  [7:0]  d, v, o7, a;
    localparam [79:0] IDX = 80'h06071012131415161730;
    always #50 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) if (hsync) hs_cnt = hs_cnt + 1;
    cvt_horiz_source #(.LINE(8)) cvt_horiz_source_inst (
        .i_core_clk(i_core_clk), .i_reset(i_reset),
        .o_char_en(char_en), .o_hsync_start(hsync));
    cvt_vertical_timing cvt_vertical_timing_inst (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_index(i_reg_index),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(rdata), .i_char_en(char_en), .i_hsync_start(hsync),
        .i_text_mode(1'b1), .i_refresh_one(i_refresh_one), .o_vsync(vs),
        .o_vblank(vb), .o_vdisp_active(vd), .o_underline(ul),
        .o_refresh_cycles(refr), .o_irq(irq), .o_irq_pending(pend),
        .o_mem_addr());
    function [7:0] exp_rb(input [7:0] x, input [7:0] dt);
        case (x)
            8'h14: exp_rb = dt & 8'h7F;
            8'h17: exp_rb = dt & 8'hEF;
            8'h30: exp_rb = 8'h00;
            default: exp_rb = dt;
        endcase
    endfunction
    function [7:0] exp_refr(input b6, input one);
        exp_refr = one ? 8'h01 : (b6 ? 8'h05 : 8'h03);
    endfunction
    task chk(input string nm, input [7:0] e, input [7:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [7:0] x, input [7:0] dt);
        @(posedge i_core_clk) #1;
        i_reg_index = x;
        i_reg_wdata = dt;
        i_reg_wr = 1'b1;
        @(posedge i_core_clk) #1;
        i_reg_wr = 1'b0;
    endtask
    task rd(input [7:0] x, output [7:0] q);
        @(posedge i_core_clk) #1;
        i_reg_index = x;
        i_reg_rd = 1'b1;
        @(posedge i_core_clk) #1;
        i_reg_rd = 1'b0;
        q = rdata;
    endtask
    // Waits for a level and compares lines elapsed since enable
    task wait_lines(input string nm, input integer s, input l, input [7:0] e);
        integer k;
        k = 0;
        while (vt[s] !== l && k < 400) begin
            @(posedge i_core_clk) #1;
            k = k + 1;
        end
        if (k == 400) fails = fails + 1;
        chk(nm, e, 8'(hs_cnt - base));
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #500000;
        fails = fails + 1;
        finish_test;
    end
    initial begin
        void'($urandom(32'hABD7));
        repeat (3) @(posedge i_core_clk);
        #1 i_reset = 1'b0;
        rd(8'h11, d);
        chk("sync_end_reset", 8'h00, d);
        chk("refresh_reset", 8'h03, {5'h00, refr});
        for (i = 0; i < 10; i = i + 1) begin
            a = IDX[79 - i * 8 -: 8];
            v = 8'($urandom);
            wr(a, v);
            rd(a, d);
            chk("readback", exp_rb(a, v), d);
        end
        rd(8'h07, o7);
        rd(8'h06, v);
        wr(8'h11, 8'h80);
        wr(8'h06, ~v);
        rd(8'h06, d);
        chk("protected_total", v, d);
        wr(8'h07, ~o7);
        rd(8'h07, d);
        chk("protected_ovfl", (o7 & 8'hEF) | (~o7 & 8'h10), d);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h11, {1'b0, i[0], 6'h00});
            i_refresh_one = i[1];
            repeat (2) @(posedge i_core_clk);
            #1 chk("refresh", exp_refr(i[0], i[1]), {5'h00, refr});
        end
        i_refresh_one = 1'b0;
        wr(8'h17, 8'h00);
        wr(8'h06, 8'd20);
        wr(8'h07, 8'h00);
        wr(8'h09, 8'h00);
        wr(8'h10, 8'd5);
        wr(8'h12, 8'd16);
        wr(8'h15, 8'd18);
        wr(8'h16, 8'd2);
        wr(8'h1B, 8'h00);
        wr(8'h14, 8'h00);
        wr(8'h11, 8'h18);
        @(posedge i_core_clk iff hsync);
        wr(8'h17, 8'h80);
        base = hs_cnt;
        wait_lines("sync_start", 0, 1'b1, 8'd5);
        chk("irq_raised", 8'h03, {6'h00, irq, pend});
        wait_lines("sync_end", 0, 1'b0, 8'd8);
        wr(8'h11, 8'h08);
        chk("irq_cleared", 8'h00, {6'h00, irq, pend});
        wr(8'h11, 8'h38);
        wait_lines("blank_start", 1, 1'b1, 8'd18);
        wait_lines("blank_end", 1, 1'b0, 8'd23);
        chk("display_on", 8'h01, {7'h00, vd});
        chk("underline", 8'h01, {7'h00, ul});
        wait_lines("display_end", 2, 1'b0, 8'd37);
        chk("irq_disabled", 8'h00, {7'h00, irq});
        wr(8'h17, 8'h00);
        repeat (2) @(posedge i_core_clk);
        #1 chk("timing_off", 8'h00, {5'h00, vt});
        finish_test;
    end
endmodule // cvt_vertical_timing_bench

// ===== bench/cvt_vertical_timing_sva.sv
// Assertion checker for the vertical timing unit
`timescale 1ns/1ps
module cvt_vertical_timing_sva (
    // Clock and reset
    input wire       i_core_clk,
    input wire       i_reset,
    // Register port
    input wire [7:0] i_reg_index,
    input wire       i_reg_wr,
    input wire [7:0] i_reg_wdata,
    // Timing inputs and outputs
    input wire       i_hsync_start,
    input wire       i_refresh_one,
    input wire       o_vsync,
    input wire       o_vblank,
    input wire       o_vdisp_active,
    input wire [2:0] o_refresh_cycles,
    input wire       o_irq,
    input wire       o_irq_pending
);
    reg [7:0] se;
    reg       ten;
    reg [5:0] vs_len;
    wire      se_wr = i_reg_wr && i_reg_index == 8'h11;
    // Shadow of sync end control and timing enable
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            se     <= 8'h00;
            ten    <= 1'b0;
            vs_len <= 6'h00;
        end else begin
            if (se_wr)
                se <= i_reg_wdata;
            if (i_reg_wr && i_reg_index == 8'h17)
                ten <= i_reg_wdata[7];
            if (!o_vsync)
                vs_len <= 6'h00;
            else if (i_hsync_start)
                vs_len <= vs_len + 6'h01;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    pend_on_sync_a: assert property ($rose(o_irq_pending) |-> $rose(o_vsync))
        else $error("pending set without sync start");
    irq_disable_a: assert property (se[5] |-> !o_irq)
        else $error("interrupt active while disabled");
    irq_gate_a: assert property (o_irq |-> o_irq_pending && se[4])
        else $error("interrupt active without pending and arm");
    irq_clear_a: assert property (se_wr && !i_reg_wdata[4] && !i_hsync_start
        |=> !o_irq_pending && !o_irq) else $error("interrupt not cleared");
    refresh_one_a: assert property (i_refresh_one [*2] |-> o_refresh_cycles == 3'h1)
        else $error("refresh count not one");
    refresh_five_a: assert property ((!i_refresh_one && se[6]) [*2]
        |-> o_refresh_cycles == 3'h5) else $error("refresh count not five");
    refresh_three_a: assert property ((!i_refresh_one && !se[6]) [*2]
        |-> o_refresh_cycles == 3'h3) else $error("refresh count not three");
    timing_off_a: assert property (!ten [*2] |-> !o_vsync && !o_vblank && !o_vdisp_active)
        else $error("timing outputs active while disabled");
    sync_width_a: assert property (vs_len <= 6'd33)
        else $error("vertical sync too long");
endmodule // cvt_vertical_timing_sva

bind cvt_vertical_timing cvt_vertical_timing_sva cvt_sva_inst (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_index(i_reg_index),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .i_hsync_start(i_hsync_start), .i_refresh_one(i_refresh_one),
    .o_vsync(o_vsync), .o_vblank(o_vblank), .o_vdisp_active(o_vdisp_active),
    .o_refresh_cycles(o_refresh_cycles), .o_irq(o_irq),
    .o_irq_pending(o_irq_pending));

// ===== logic/cvt_vertical_timing.v
// Vertical timing, interrupt and display address generation
`timescale 1ns/1ps
`include "cvt_consts.vh"

module cvt_vertical_timing #(
    parameter ADDR_W = 16
) (
    // Clock and reset
    input  wire              i_core_clk,
    input  wire              i_reset,
    // Indexed register port
    input  wire [7:0]        i_reg_index,
    input  wire              i_reg_wr,
    input  wire              i_reg_rd,
    input  wire [7:0]        i_reg_wdata,
    output reg  [7:0]        o_reg_rdata,
    // Timing strobes from the horizontal unit, text mode and refresh variant inputs
    input  wire              i_char_en,
    input  wire              i_hsync_start,
    input  wire              i_text_mode,
    input  wire              i_refresh_one,
    // Vertical outputs
    output reg               o_vsync,
    output reg               o_vblank,
    output reg               o_vdisp_active,
    output reg               o_underline,
    output reg  [2:0]        o_refresh_cycles,
    // Interrupt
    output wire              o_irq,
    output reg               o_irq_pending,
    // Display memory address
    output reg  [ADDR_W-1:0] o_mem_addr
);

    reg  [7:0]        vtotal_low;
    reg  [7:0]        vert_overflow;
    reg  [7:0]        cell_height_reg;
    reg  [7:0]        vsync_start_low;
    reg  [7:0]        vsync_end_ctrl;
    reg  [7:0]        vdisp_end_low;
    reg  [7:0]        row_pitch;
    reg  [7:0]        underline_addr_mode;
    reg  [7:0]        vblank_start_low;
    reg  [7:0]        vblank_end_low;
    reg  [7:0]        mode_control;
    reg  [7:0]        ext_display_ctrl;

    reg  [9:0]        scanline;
    reg  [4:0]        row_scan;
    reg               hs_half;
    reg  [1:0]        char_div;
    reg  [ADDR_W-1:0] row_start;
    reg  [ADDR_W-1:0] addr_cnt;

    wire protect   = vsync_end_ctrl[`CVT_SE_PROT];
    wire wr_prot   = i_reg_index <= `CVT_IDX_PROT_TOP;
    wire timing_on = mode_control[`CVT_MC_TEN];
    wire dword     = underline_addr_mode[`CVT_UL_DWORD];
    wire byte_mode = mode_control[`CVT_MC_BYTE];

    // Assembled vertical fields
    wire [9:0] vtotal = {1'b0, vert_overflow[`CVT_OV_VT8], vtotal_low};
    wire [9:0] vss    = {1'b0, vert_overflow[`CVT_OV_VSS8],
                         vsync_start_low};
    wire [9:0] vde    = {1'b0, vert_overflow[`CVT_OV_VDE8], vdisp_end_low};
    wire [9:0] vbs    = {cell_height_reg[`CVT_CH_VBS9],
                         vert_overflow[`CVT_OV_VBS8], vblank_start_low};
    wire [8:0] pitch  = {ext_display_ctrl[`CVT_EX_PITCH8], row_pitch};

    // Register writes
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            vtotal_low          <= `CVT_REG_RESET;
            vert_overflow       <= `CVT_REG_RESET;
            cell_height_reg     <= `CVT_REG_RESET;
            vsync_start_low     <= `CVT_REG_RESET;
            vsync_end_ctrl      <= `CVT_REG_RESET;
            vdisp_end_low       <= `CVT_REG_RESET;
            row_pitch           <= `CVT_REG_RESET;
            underline_addr_mode <= `CVT_REG_RESET;
            vblank_start_low    <= `CVT_REG_RESET;
            vblank_end_low      <= `CVT_REG_RESET;
            mode_control        <= `CVT_REG_RESET;
            ext_display_ctrl    <= `CVT_REG_RESET;
        end else if (i_reg_wr) begin
            if (!(protect && wr_prot)) begin
                if (i_reg_index == `CVT_IDX_VTOTAL)
                    vtotal_low <= i_reg_wdata;
                if (i_reg_index == `CVT_IDX_OVFL)
                    vert_overflow <= i_reg_wdata;
            end else if (i_reg_index == `CVT_IDX_OVFL) begin
                vert_overflow[`CVT_OV_LC8] <= i_reg_wdata[`CVT_OV_LC8];
            end
            case (i_reg_index)
                `CVT_IDX_CELL:  cell_height_reg     <= i_reg_wdata;
                `CVT_IDX_VSS:   vsync_start_low     <= i_reg_wdata;
                `CVT_IDX_VSE:   vsync_end_ctrl      <= i_reg_wdata;
                `CVT_IDX_VDE:   vdisp_end_low       <= i_reg_wdata;
                `CVT_IDX_PITCH: row_pitch           <= i_reg_wdata;
                `CVT_IDX_ULINE: underline_addr_mode <= i_reg_wdata;
                `CVT_IDX_VBS:   vblank_start_low    <= i_reg_wdata;
                `CVT_IDX_VBE:   vblank_end_low      <= i_reg_wdata;
                `CVT_IDX_MODE:  mode_control        <= i_reg_wdata;
                `CVT_IDX_EXT:   ext_display_ctrl    <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Register reads, reserved bits as zero
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reg_rdata <= `CVT_REG_RESET;
        end else if (i_reg_rd) begin
            case (i_reg_index)
                `CVT_IDX_VTOTAL: o_reg_rdata <= vtotal_low;
                `CVT_IDX_OVFL:   o_reg_rdata <= vert_overflow;
                `CVT_IDX_CELL:   o_reg_rdata <= cell_height_reg;
                `CVT_IDX_VSS:    o_reg_rdata <= vsync_start_low;
                `CVT_IDX_VSE:    o_reg_rdata <= vsync_end_ctrl;
                `CVT_IDX_VDE:    o_reg_rdata <= vdisp_end_low;
                `CVT_IDX_PITCH:  o_reg_rdata <= row_pitch;
                `CVT_IDX_ULINE:  o_reg_rdata <= {1'b0,
                                     underline_addr_mode[6:0]};
                `CVT_IDX_VBS:    o_reg_rdata <= vblank_start_low;
                `CVT_IDX_VBE:    o_reg_rdata <= vblank_end_low;
                `CVT_IDX_MODE:   o_reg_rdata <= {mode_control[7:5], 1'b0,
                                     mode_control[3:0]};
                `CVT_IDX_EXT:    o_reg_rdata <= ext_display_ctrl;
                default:         o_reg_rdata <= `CVT_REG_RESET;
            endcase
        end
    end

    // Scanline advance, optionally every second hsync
    wire line_tick = timing_on && i_hsync_start &&
                     (!mode_control[`CVT_MC_VDBL] || hs_half);
    wire [9:0] next_scanline = (scanline == vtotal) ? 10'h000
                                                    : scanline + 10'h001;
    wire [7:0] vbe_low_cmp = next_scanline[7:0];
    wire vbe_hit = ext_display_ctrl[`CVT_EX_VBE_EXT]
                   ? (next_scanline == {2'b00, vblank_end_low})
                   : (vbe_low_cmp == vblank_end_low);
    wire vss_hit = next_scanline == vss;
    wire new_row = (row_scan == cell_height_reg[4:0]);
    wire [4:0] next_row_scan = (next_scanline == 10'h000 || new_row)
                               ? 5'h00 : row_scan + 5'h01;

    always @(posedge i_core_clk) begin
        if (i_reset || !timing_on) begin
            scanline       <= 10'h000;
            row_scan       <= 5'h00;
            hs_half        <= 1'b0;
            o_vsync        <= 1'b0;
            o_vblank       <= 1'b0;
            o_vdisp_active <= 1'b0;
            o_underline    <= 1'b0;
        end else begin
            if (i_hsync_start)
                hs_half <= ~hs_half;
            if (line_tick) begin
                scanline <= next_scanline;
                row_scan <= next_row_scan;
                if (vss_hit)
                    o_vsync <= 1'b1;
                else if (next_scanline[3:0] == vsync_end_ctrl[3:0])
                    o_vsync <= 1'b0;
                if (next_scanline == vbs)
                    o_vblank <= 1'b1;
                else if (vbe_hit)
                    o_vblank <= 1'b0;
                if (next_scanline == vde)
                    o_vdisp_active <= 1'b0;
                else if (next_scanline == 10'h000)
                    o_vdisp_active <= 1'b1;
                o_underline <= i_text_mode &&
                    (next_row_scan == underline_addr_mode[4:0]);
            end
        end
    end

    // Vertical interrupt; a set in the clearing cycle wins
    wire irq_set = line_tick && vss_hit && !o_vsync &&
                   !vsync_end_ctrl[`CVT_SE_IDIS] &&
                   vsync_end_ctrl[`CVT_SE_ICLR];
    wire irq_clr = (i_reg_wr && i_reg_index == `CVT_IDX_VSE &&
                    !i_reg_wdata[`CVT_SE_ICLR]) ||
                   !vsync_end_ctrl[`CVT_SE_ICLR];

    always @(posedge i_core_clk) begin
        if (i_reset)
            o_irq_pending <= 1'b0;
        else if (irq_set)
            o_irq_pending <= 1'b1;
        else if (irq_clr)
            o_irq_pending <= 1'b0;
    end

    assign o_irq = o_irq_pending && !vsync_end_ctrl[`CVT_SE_IDIS] &&
                   vsync_end_ctrl[`CVT_SE_ICLR];

    // Refresh cycles per scanline
    always @(posedge i_core_clk) begin
        if (i_reset)
            o_refresh_cycles <= `CVT_REFR_THREE;
        else if (i_refresh_one)
            o_refresh_cycles <= `CVT_REFR_ONE;
        else if (vsync_end_ctrl[`CVT_SE_REFR])
            o_refresh_cycles <= `CVT_REFR_FIVE;
        else
            o_refresh_cycles <= `CVT_REFR_THREE;
    end

    // Address counter rate: full, half or quarter character clock
    wire addr_adv = i_char_en && (underline_addr_mode[`CVT_UL_BY4]
                    ? (char_div == 2'h3)
                    : (!mode_control[`CVT_MC_BY2] || char_div[0]));
    wire [ADDR_W-1:0] pitch_step = dword
        ? {{(ADDR_W-11){1'b0}}, pitch, 2'b00}
        : {{(ADDR_W-10){1'b0}}, pitch, 1'b0};
    // First line of a frame starts at zero, later rows add the pitch
    wire [ADDR_W-1:0] next_row_start = (next_scanline == 10'h000)
                      ? {ADDR_W{1'b0}}
                      : (new_row ? row_start + pitch_step : row_start);

    always @(posedge i_core_clk) begin
        if (i_reset || !timing_on) begin
            char_div  <= 2'h0;
            row_start <= {ADDR_W{1'b0}};
            addr_cnt  <= {ADDR_W{1'b0}};
        end else if (line_tick) begin
            char_div  <= 2'h0;
            row_start <= next_row_start;
            addr_cnt  <= next_row_start;
        end else if (i_char_en) begin
            char_div <= char_div + 2'h1;
            if (addr_adv)
                addr_cnt <= addr_cnt + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
    end

    // Address rotation toward display memory
    always @(posedge i_core_clk) begin
        if (i_reset)
            o_mem_addr <= {ADDR_W{1'b0}};
        else if (dword)
            o_mem_addr <= {addr_cnt[ADDR_W-1:14], addr_cnt[11:0],
                           addr_cnt[13:12]};
        else if (byte_mode)
            o_mem_addr <= addr_cnt;
        else if (mode_control[`CVT_MC_WRAP])
            o_mem_addr <= {addr_cnt[ADDR_W-2:0],
                           addr_cnt[ADDR_W-1]};
        else
            o_mem_addr <= {addr_cnt[ADDR_W-1:14], addr_cnt[12:0],
                           addr_cnt[13]};
    end

endmodule // cvt_vertical_timing

// ===== shared/cvt_consts.vh
// Constants for the vertical timing and addressing unit
// Behaviour
// - Vertical sync starts when scanline counter equals the vertical sync start field.
// - With write-protect set, writes to indices 0-7 are ignored, except line-compare extension.
// - Refresh cycle bit selects five or three cycles per line; variant forces one.
// - Interrupt disable set keeps the interrupt output inactive.
// - Clear bit at 0 clears pending and output; 1 re-arms the interrupt.
// - Vertical sync ends when counter low four bits equal sync end field.
// - Active display ends at the scanline given by vertical display end.
// - Each new row adds the shifted 9-bit row pitch to previous row start.
// - Doubleword mode rotates counter left two; address bits 1:0 from 13:12.
// - Count-by-four clocks the address counter at quarter character rate.
// - In text modes underline is drawn on the cell scanline from the field.
// - Vertical blank starts at the vertical blank start field.
// - Vertical blank ends on match with blank end field; 8 bits without extension.
// - Timing enable runs the timing logic; zero stops it.
// - Byte mode sends counter unrotated; word mode rotates left one place.
// - In word mode the wrap bit selects a 16- or 14-bit rotation.
// - Count-by-two clocks the address counter at half character rate.
// - Vertical doubling counts scanlines on every second horizontal sync.
// - Overflow bit 2 supplies bit 8 of the vertical sync start field.
`ifndef CVT_CONSTS_VH
`define CVT_CONSTS_VH
`define CVT_IDX_VTOTAL    8'h06
`define CVT_IDX_OVFL      8'h07
`define CVT_IDX_CELL      8'h09
`define CVT_IDX_VSS       8'h10
`define CVT_IDX_VSE       8'h11
`define CVT_IDX_VDE       8'h12
`define CVT_IDX_PITCH     8'h13
`define CVT_IDX_ULINE     8'h14
`define CVT_IDX_VBS       8'h15
`define CVT_IDX_VBE       8'h16
`define CVT_IDX_MODE      8'h17
`define CVT_IDX_EXT       8'h1B
`define CVT_IDX_PROT_TOP  8'h07
`define CVT_OV_VT8        0
`define CVT_OV_VDE8       1
`define CVT_OV_VSS8       2
`define CVT_OV_VBS8       3
`define CVT_OV_LC8        4
`define CVT_CH_VBS9       5
`define CVT_SE_PROT       7
`define CVT_SE_REFR       6
`define CVT_SE_IDIS       5
`define CVT_SE_ICLR       4
`define CVT_UL_DWORD      6
`define CVT_UL_BY4        5
`define CVT_MC_TEN        7
`define CVT_MC_BYTE       6
`define CVT_MC_WRAP       5
`define CVT_MC_BY2        3
`define CVT_MC_VDBL       2
`define CVT_EX_VBE_EXT    5
`define CVT_EX_PITCH8     4
`define CVT_REFR_FIVE     3'h5
`define CVT_REFR_THREE    3'h3
`define CVT_REFR_ONE      3'h1
`define CVT_REG_RESET     8'h00
`endif
